// ---- verilog/isafid_regs.vh ----
// Offsets, field positions and feature levels of the instruction attribute registers
`ifndef ISAFID_REGS_VH
`define ISAFID_REGS_VH

// ----------------------------------------------------------------------------
// Register word offsets (byte addresses)
// ----------------------------------------------------------------------------
`define ISAFID_ADDR_W 8
`define ISAFID_OFF_ATTR_TWO 8'h00
`define ISAFID_OFF_ATTR_THREE 8'h04
`define ISAFID_OFF_ATTR_FOUR 8'h08

// ----------------------------------------------------------------------------
// Field low-bit positions, all fields four bits wide
// ----------------------------------------------------------------------------
`define ISAFID_FW 4
`define ISAFID_A2_REVERSE 28
`define ISAFID_A2_UMUL 20
`define ISAFID_A2_SMUL 16
`define ISAFID_A2_MUL 12
`define ISAFID_A2_MACC 8
`define ISAFID_A2_HINT 4
`define ISAFID_A2_DUALLS 0
`define ISAFID_A3_NOOP 24
`define ISAFID_A3_MOVE 20
`define ISAFID_A3_TBR 16
`define ISAFID_A3_EXCL 12
`define ISAFID_A3_SVC 8
`define ISAFID_A3_SIMD 4
`define ISAFID_A3_SAT 0
`define ISAFID_A4_PSR 24
`define ISAFID_A4_EXCL 20
`define ISAFID_A4_BAR 16
`define ISAFID_A4_WB 8
`define ISAFID_A4_SHIFT 4
`define ISAFID_A4_UNPRIV 0

// ----------------------------------------------------------------------------
// Default implemented feature levels
// ----------------------------------------------------------------------------
`define ISAFID_LVL_REVERSE 4'h2
`define ISAFID_LVL_UMUL 4'h2
`define ISAFID_LVL_SMUL 4'h3
`define ISAFID_LVL_MUL 4'h2
`define ISAFID_LVL_MACC 4'h2
`define ISAFID_LVL_HINT 4'h3
`define ISAFID_LVL_DUALLS 4'h1
`define ISAFID_LVL_NOOP 4'h1
`define ISAFID_LVL_MOVE 4'h1
`define ISAFID_LVL_TBR 4'h1
`define ISAFID_LVL_EXCL_MAJ 4'h1
`define ISAFID_LVL_EXCL_MIN 4'h3
`define ISAFID_LVL_SVC 4'h1
`define ISAFID_LVL_SIMD 4'h3
`define ISAFID_LVL_SAT 4'h1
`define ISAFID_LVL_PSR 4'h1
`define ISAFID_LVL_BAR 4'h1
`define ISAFID_LVL_WB 4'h1
`define ISAFID_LVL_SHIFT 4'h3
`define ISAFID_LVL_UNPRIV 4'h2
`define ISAFID_LVL_EXTEND 4'h2
`define ISAFID_RSVD 4'h0

`endif

// ---- verilog/isafid_regs.v ----
// Read-only instruction set attribute registers two to four
`timescale 1ns/100ps
`default_nettype none
`include "isafid_regs.vh"

module isafid_regs (
  input wire i_mclk,
  input wire i_srst,
  input wire [7:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [31:0] o_rdata,
  output reg o_sat_flag_present,
  output reg o_ge_flags_present,
  output reg o_dual_extend_present
);

  // --------------------------------------------------------------------------
  // Legalising helpers
  // --------------------------------------------------------------------------
  // Clamp a 0..2 level; anything higher becomes the top legal level
  function [3:0] isafid_lvl2;
    input [3:0] v;
    begin
      isafid_lvl2 = (v > 4'h2) ? 4'h2 : v;
    end
  endfunction

  // Reserved codes must never be shown, so they drop to a lower legal value
  function [3:0] isafid_simd;
    input [3:0] v;
    begin
      if (v == 4'h2)
        isafid_simd = 4'h1;
      else if (v > 4'h3)
        isafid_simd = 4'h3;
      else
        isafid_simd = v;
    end
  endfunction

  function [3:0] isafid_shift;
    input [3:0] v;
    begin
      if (v == 4'h2)
        isafid_shift = 4'h1;
      else if (v > 4'h3)
        isafid_shift = 4'h3;
      else
        isafid_shift = v;
    end
  endfunction

  // --------------------------------------------------------------------------
  // Fixed field values
  // --------------------------------------------------------------------------
  wire [3:0] f_rev = isafid_lvl2(`ISAFID_LVL_REVERSE);
  wire [3:0] f_umul = isafid_lvl2(`ISAFID_LVL_UMUL);
  wire [3:0] f_smul = (`ISAFID_LVL_SMUL > 4'h3) ? 4'h3 : `ISAFID_LVL_SMUL;
  wire [3:0] f_mul = isafid_lvl2(`ISAFID_LVL_MUL);
  wire [3:0] f_macc = isafid_lvl2(`ISAFID_LVL_MACC);
  wire [3:0] f_hint = (`ISAFID_LVL_HINT > 4'h3) ? 4'h3 : `ISAFID_LVL_HINT;
  wire [3:0] f_dls = {3'h0, `ISAFID_LVL_DUALLS != 4'h0};
  wire [3:0] f_noop = {3'h0, `ISAFID_LVL_NOOP != 4'h0};
  wire [3:0] f_move = {3'h0, `ISAFID_LVL_MOVE != 4'h0};
  wire [3:0] f_tbr = {3'h0, `ISAFID_LVL_TBR != 4'h0};
  wire [3:0] f_svc = {3'h0, `ISAFID_LVL_SVC != 4'h0};
  wire [3:0] f_simd = isafid_simd(`ISAFID_LVL_SIMD);
  wire [3:0] f_sat = {3'h0, `ISAFID_LVL_SAT != 4'h0};
  wire [3:0] f_psr = {3'h0, `ISAFID_LVL_PSR != 4'h0};
  wire [3:0] f_bar = {3'h0, `ISAFID_LVL_BAR != 4'h0};
  wire [3:0] f_wb = {3'h0, `ISAFID_LVL_WB != 4'h0};
  wire [3:0] f_shift = isafid_shift(`ISAFID_LVL_SHIFT);
  wire [3:0] f_unpriv = isafid_lvl2(`ISAFID_LVL_UNPRIV);

  // Exclusive pair: only the four listed pairings may appear
  wire excl_ok = ((`ISAFID_LVL_EXCL_MAJ == 4'h0) && (`ISAFID_LVL_EXCL_MIN == 4'h0)) ||
                 ((`ISAFID_LVL_EXCL_MAJ == 4'h1) && (`ISAFID_LVL_EXCL_MIN == 4'h0)) ||
                 ((`ISAFID_LVL_EXCL_MAJ == 4'h1) && (`ISAFID_LVL_EXCL_MIN == 4'h3)) ||
                 ((`ISAFID_LVL_EXCL_MAJ == 4'h2) && (`ISAFID_LVL_EXCL_MIN == 4'h0));
  wire [3:0] f_exmaj = excl_ok ? `ISAFID_LVL_EXCL_MAJ : 4'h0;
  wire [3:0] f_exmin = excl_ok ? `ISAFID_LVL_EXCL_MIN : 4'h0;

  // --------------------------------------------------------------------------
  // Register images
  // --------------------------------------------------------------------------
  // Reserved nibbles are tied to zero so they never carry meaning
  wire [31:0] attr_two = {f_rev, `ISAFID_RSVD, f_umul, f_smul,
                          f_mul, f_macc, f_hint, f_dls};
  wire [31:0] attr_three = {`ISAFID_RSVD, f_noop, f_move, f_tbr,
                            f_exmaj, f_svc, f_simd, f_sat};
  wire [31:0] attr_four = {`ISAFID_RSVD, f_psr, f_exmin, f_bar,
                           `ISAFID_RSVD, f_wb, f_shift, f_unpriv};

  // Read mux; unmapped addresses answer zero
  reg [31:0] next_rdata;
  always @* begin
    next_rdata = 32'h0000_0000;
    case (i_addr)
      `ISAFID_OFF_ATTR_TWO: next_rdata = attr_two;
      `ISAFID_OFF_ATTR_THREE: next_rdata = attr_three;
      `ISAFID_OFF_ATTR_FOUR: next_rdata = attr_four;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  // Read data stands only the cycle after the strobe; writes are ignored
  always @(posedge i_mclk) begin
    if (i_srst) begin
      o_rdata <= 32'h0000_0000;
      o_sat_flag_present <= 1'b0;
      o_ge_flags_present <= 1'b0;
      o_dual_extend_present <= 1'b0;
    end else begin
      o_rdata <= i_rd ? next_rdata : 32'h0000_0000;
      o_sat_flag_present <= (f_smul > 4'h1) || (f_sat > 4'h0) ||
                            (f_simd > 4'h0);
      o_ge_flags_present <= (f_simd == 4'h3);
      o_dual_extend_present <= (f_simd == 4'h3) &&
                               (`ISAFID_LVL_EXTEND >= 4'h2);
    end
  end

  // Write port deliberately has no effect on the read-only image
  wire unused_wr = i_wr ^ (^i_wdata);

endmodule
`default_nettype wire

// ---- verification/isafid_regs_props.sv ----
// Checker for the attribute register read port
`timescale 1ns/100ps
`default_nettype none
`include "isafid_regs.vh"

module isafid_regs_props (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic [7:0] i_addr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic o_sat_flag_present,
  input wire logic o_ge_flags_present,
  input wire logic o_dual_extend_present
);
  // Expected words built from field positions and levels
  localparam logic [31:0] exp_two = {`ISAFID_LVL_REVERSE, `ISAFID_RSVD, `ISAFID_LVL_UMUL,
    `ISAFID_LVL_SMUL, `ISAFID_LVL_MUL, `ISAFID_LVL_MACC, `ISAFID_LVL_HINT, `ISAFID_LVL_DUALLS};
  localparam logic [31:0] exp_three = {`ISAFID_RSVD, `ISAFID_LVL_NOOP, `ISAFID_LVL_MOVE,
    `ISAFID_LVL_TBR, `ISAFID_LVL_EXCL_MAJ, `ISAFID_LVL_SVC, `ISAFID_LVL_SIMD, `ISAFID_LVL_SAT};
  localparam logic [31:0] exp_four = {`ISAFID_RSVD, `ISAFID_LVL_PSR, `ISAFID_LVL_EXCL_MIN,
    `ISAFID_LVL_BAR, `ISAFID_RSVD, `ISAFID_LVL_WB, `ISAFID_LVL_SHIFT, `ISAFID_LVL_UNPRIV};
  localparam logic sat_exp = (`ISAFID_LVL_SMUL > 4'h1) || (`ISAFID_LVL_SAT > 4'h0)
    || (`ISAFID_LVL_SIMD > 4'h0);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  // ------------------------------------------------------------
  // Read port timing and contents
  // ------------------------------------------------------------
  a_read_two_word: assert property (i_rd && i_addr == 8'h00 |=> o_rdata == exp_two) else $error("attr two word wrong");
  a_read_three_word: assert property (i_rd && i_addr == 8'h04 |=> o_rdata == exp_three) else $error("attr three word wrong");
  a_read_four_word: assert property (i_rd && i_addr == 8'h08 |=> o_rdata == exp_four) else $error("attr four word wrong");
  a_idle_data_zero: assert property (!i_rd |=> o_rdata == 32'h0) else $error("read data stands too long");
  a_unmapped_zero: assert property (i_rd && i_addr > 8'h08 |=> o_rdata == 32'h0) else $error("unmapped read not zero");
  // Status levels, only checked once reset has been low an edge
  a_sat_flag_level: assert property (!i_srst |=> o_sat_flag_present == sat_exp) else $error("saturation flag level wrong");
  a_ge_flags_level: assert property (!i_srst |=> o_ge_flags_present == (`ISAFID_LVL_SIMD == 4'h3)) else $error("ge flags level wrong");
  a_dual_ext_level: assert property (!i_srst |=> o_dual_extend_present == (`ISAFID_LVL_SIMD == 4'h3 && `ISAFID_LVL_EXTEND >= 4'h2)) else $error("dual extend level wrong");
endmodule

bind isafid_regs isafid_regs_props u_props (.i_mclk(i_mclk), .i_srst(i_srst), .i_addr(i_addr),
  .i_rd(i_rd), .o_rdata(o_rdata), .o_sat_flag_present(o_sat_flag_present),
  .o_ge_flags_present(o_ge_flags_present), .o_dual_extend_present(o_dual_extend_present));
`default_nettype wire

// ---- verification/isafid_regs_tb.sv ----
// Self-checking bench for the attribute register block
`timescale 1ns/100ps
`default_nettype none
`include "isafid_regs.vh"

module isafid_regs_tb;
  logic [31:0] exp_w [3] = '{{`ISAFID_LVL_REVERSE, `ISAFID_RSVD, `ISAFID_LVL_UMUL,
    `ISAFID_LVL_SMUL, `ISAFID_LVL_MUL, `ISAFID_LVL_MACC, `ISAFID_LVL_HINT, `ISAFID_LVL_DUALLS},
    {`ISAFID_RSVD, `ISAFID_LVL_NOOP, `ISAFID_LVL_MOVE, `ISAFID_LVL_TBR, `ISAFID_LVL_EXCL_MAJ,
    `ISAFID_LVL_SVC, `ISAFID_LVL_SIMD, `ISAFID_LVL_SAT}, {`ISAFID_RSVD, `ISAFID_LVL_PSR,
    `ISAFID_LVL_EXCL_MIN, `ISAFID_LVL_BAR, `ISAFID_RSVD, `ISAFID_LVL_WB, `ISAFID_LVL_SHIFT,
    `ISAFID_LVL_UNPRIV}};
  logic i_mclk = 1'b0, i_srst = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0, o_rdata, d3, d4;
  logic o_sat, o_ge, o_dext;
  int num_errors = 0, total_checks = 0;
  isafid_regs uut (.i_mclk(i_mclk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_sat_flag_present(o_sat),
    .o_ge_flags_present(o_ge), .o_dual_extend_present(o_dext));
  // ------------------------------------------------------------
  // Bus cycles and comparison
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Data is only valid in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic wr(input logic [7:0] a);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= 32'hffff_ffff;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_status;
    repeat (2) @(posedge i_mclk);
    #1 chk("sat", 32'h1, {31'h0, o_sat});
    chk("ge", 32'h1, {31'h0, o_ge});
    chk("dext", 32'h1, {31'h0, o_dext});
    chk("idle", 32'h0, o_rdata);
  endtask
  // Strobes with no gap; each word is judged one cycle late
  task automatic t_back_to_back;
    for (int i = 0; i < 4; i++) begin
      @(posedge i_mclk);
      i_rd <= (i < 3);
      i_addr <= 8'(4 * i);
      #1 if (i > 0) chk("word", exp_w[i-1], o_rdata);
    end
    #25 chk("after", 32'h0, o_rdata);
  endtask
  // Reserved codes must never appear
  task automatic t_legal_codes;
    rd(8'h04, d3);
    rd(8'h08, d4);
    chk("excl", 32'h1, 32'({d3[15:12], d4[23:20]} inside {8'h00, 8'h10, 8'h13, 8'h20}));
    chk("simd", 32'h1, 32'(d3[7:4] != 4'h2));
    chk("shift", 32'h1, 32'(d4[7:4] != 4'h2 && d4[7:4] != 4'h4));
  endtask
  task automatic t_writes_unmapped;
    for (int i = 0; i < 3; i++) begin
      wr(8'(4 * i));
      rd(8'(4 * i), d3);
      chk("after write", exp_w[i], d3);
    end
    rd(8'h0c, d3);
    chk("unmapped", 32'h0, d3);
  endtask
  // Reset lands while a read is in flight
  task automatic t_mid_reset;
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_srst <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 chk("reset data", 32'h0, o_rdata);
    chk("reset sat", 32'h0, {31'h0, o_sat});
    @(posedge i_mclk);
    i_srst <= 1'b0;
    t_status();
  endtask
  task final_report;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    forever #12.5 i_mclk = ~i_mclk;
  end
  // Whole run is well under a hundred cycles past reset
  initial begin
    #20000;
    num_errors++;
    final_report();
  end
  initial begin
    repeat (16) @(posedge i_mclk);
    i_srst <= 1'b0;
    t_status();
    t_back_to_back();
    t_legal_codes();
    t_writes_unmapped();
    t_mid_reset();
    final_report();
  end
endmodule
`default_nettype wire
